// *** bus_ctl_model.sv ***
/*
 * Behavioural bus controller and host facing the DMA peripheral:
 * status pins, command, address, write/read, data and ready.
 * Assumes the bench calls slave_cycle only while the device is in slave mode.
 */
`timescale 1ns/1ps
module bus_ctl_model (
  input wire logic clk,          // Bus clock
  input wire logic [3:0] st_out, // Device status drive
  input wire logic st_oe_n,      // Device status enable
  input wire logic rdy_out,      // Device ready drive
  input wire logic rdy_oe_n,     // Device ready enable
  input wire logic [7:0] d_out,  // Device data drive
  input wire logic d_oe_n,       // Device data enable
  input wire logic rdy_level,    // Ready offered in master mode
  input wire logic rdy_on,       // Model drives ready
  output logic [3:0] st_pin,     // Resolved status pins
  output logic rdy_pin,          // Resolved ready pin
  output logic [7:0] d_pin,      // Resolved data pins
  output logic [31:2] ha,        // Host address
  output logic hwr,              // Host write/read
  output logic cmd_n             // Command strobe
);
  logic [3:0] st_drv = 4'hF; // Idle status matches the pull-up level
  logic [7:0] d_drv = 8'h00; // Write data
  logic d_en = 1'b0;         // Model drives data
  logic [7:0] d_last = 8'h00; // Last data level on the pins

  // Start with an idle bus
  initial begin
    ha = '0;
    hwr = 1'b0;
    cmd_n = 1'b1;
  end

  // Weak pull-ups keep status and ready high when nobody drives
  assign st_pin = !st_oe_n ? st_out : st_drv;
  assign rdy_pin = !rdy_oe_n ? rdy_out : (rdy_on ? rdy_level : 1'b1);
  // Data has no pull-up: a released bus must not look like stale data
  assign d_pin = !d_oe_n ? d_out : (d_en ? d_drv : ~d_last);

  // Remember the last level so the floating value keeps moving
  always @(posedge clk) begin
    d_last <= d_pin;
  end

  // One slave cycle; hold sets the command length, short or long
  task automatic slave_cycle(input logic [31:2] a, input logic mem, input logic wr,
                             input logic interrupt_acknowledge_n, input logic [7:0] wd, input int hold);
    @(posedge clk);
    st_drv <= {2'b01, mem, 1'b0};
    ha <= a;
    hwr <= wr;
    d_drv <= wd;
    d_en <= wr;
    @(posedge clk);
    st_drv[0] <= 1'b1;
    repeat (3) @(posedge clk);
    cmd_n <= 1'b0;
    st_drv[2] <= ~interrupt_acknowledge_n; // Int ack level set with the command, not with the address
    repeat (hold) @(posedge clk);
    cmd_n <= 1'b1;
    st_drv <= 4'hF;
    repeat (5) @(posedge clk);
    d_en <= 1'b0;
  endtask : slave_cycle
endmodule : bus_ctl_model

// *** dma_bus_if_map.svh ***
/*
 * Offsets, limits, status codes and timing counts of the DMA peripheral
 * bus interface. Assumes a 100 ns bus clock; definitions only.
 */
`ifndef DMA_BUS_IF_MAP_SVH
`define DMA_BUS_IF_MAP_SVH

// Bus clock period
`define CLK_PERIOD_NS 100
// Master-mode first ready sample, 2.5 bus clocks after size leaves idle
`define RDY_SAMPLE_NS 250
`define RDY_SAMPLE_CYC ((`RDY_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Slave-mode ready low time, four bus clocks after T2
`define RDY_LOW_NS 400
`define RDY_LOW_CYC ((`RDY_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Address range limits
`define ADDR_16MB_LIMIT 32'h00FF_FFFF
`define ADDR_1MB_LIMIT 32'h000F_FFFF
// Status size field idle code
`define SIZE_IDLE 2'h3
// I/O window of the register block, matched on host address bits 15:12
`define REG_BLOCK_BASE 4'h0

`endif

// *** dma_bus_if_pkg.sv ***
/*
 * Types of the DMA peripheral bus interface: slave states, the DMA
 * control bundle, the register access bundle and the core state.
 * Assumes dma_bus_if_map.svh supplies all numbers.
 */
package dma_bus_if_pkg;

  // Slave cycle states, Gray coded along idle, addressed, active
  typedef enum logic [1:0] {
    SL_IDLE = 2'h0,
    SL_ADDR = 2'h1,
    SL_ACTIVE = 2'h3
  } slave_state_t;

  // Control from the internal DMA engine
  typedef struct packed {
    logic owns;          // DMA controller owns the bus
    logic refresh;       // Refresh cycle in progress
    logic [31:2] addr;   // DMA address being driven
    logic [1:0] timing;  // Programmed cycle timing
    logic [1:0] size;    // Slave size code
    logic active;        // Transfer in progress
    logic page_break;    // Burst meets a page break
    logic last;          // Burst about to end
  } dma_ctl_t;

  // Register access toward the internal register file
  typedef struct packed {
    logic wr;            // Write pulse
    logic rd;            // Read pulse
    logic int_ack;       // Interrupt acknowledge read
    logic [13:0] addr;   // Latched host address bits 15:2
    logic [7:0] wdata;   // Write data
  } reg_access_t;

  // Whole state of the interface core
  typedef struct packed {
    slave_state_t sl;
    logic strobe_prev;
    logic [13:0] lat_addr;
    logic lat_mem;
    logic lat_wr;
    logic hit;
    logic sel_n;
    logic rdy_out;
    logic rdy_oe_n;
    logic [2:0] rdy_cnt;
    logic [7:0] dout;
    logic dout_oe_n;
    reg_access_t acc;
    logic [3:0] st_out;
    logic st_oe_n;
    logic [1:0] first_cnt;
    logic armed;
    logic pipelining;
    logic tail;
    logic dma_ready;
    logic gt16_n;
    logic gt16_oe_n;
    logic gt1_n;
    logic aen_n;
    logic rst_drv;
    logic bus_free;
  } core_state_t;

endpackage : dma_bus_if_pkg

// *** dma_peripheral_bus_interface.sv ***
/*
 * Pin-level bus interface of the DMA peripheral: address range flags,
 * expansion reset, status port in master and slave mode, ready
 * handshake, slave data bus, slave select and address enable.
 * Assumes one 10 MHz bus clock, pins arriving asynchronously, and the
 * DMA engine and register file living beside it on the same clock.
 */
`timescale 1ns/1ps
`include "dma_bus_if_map.svh"

// Functional notes
// [RULE_01] Above-16MB flag low for DMA addresses
// [RULE_02] Drive 16MB flag only under DMA ownership
// [RULE_03] Above-1MB flag decoded from address 31:20
// [RULE_04] Reset clears state, drives expansion reset
// [RULE_05] Controller holds reset eight clocks
// [RULE_06] Master status 1:0 carry cycle timing
// [RULE_07] Master status 3:2 carry slave size
// [RULE_08] Timing status changes on one clock edge
// [RULE_09] Size active, idle after last or break; the code idles size on page_break or when dma.active drops, not on dma.last
// [RULE_10] Strobe rise latches address, mem/io, write
// [RULE_11] Latched bit1 high means memory cycle
// [RULE_12] Interrupt acknowledge sampled at T2
// [RULE_13] Cycle-in-progress sampled to find bus free
// [RULE_14] Status pins driven only in DMA/refresh
// [RULE_15] Ready low only for long ISA cycles
// [RULE_16] Ready low four clocks, released with command
// [RULE_17] First ready sample starts burst pipelining
// [RULE_18] Ready sampled each edge for completion
// [RULE_19] Data bus driven on selected reads only
// [RULE_20] Slave select from T2, released with command
// [RULE_21] Slave select on interrupt acknowledge too
// [RULE_22] Address enable low under DMA or refresh
// [RULE_23] Data buffers float when command ends
module dma_peripheral_bus_interface (
  input wire logic clk,                        // Bus clock
  input wire logic rst_n,                      // System reset, active low
  input wire dma_bus_if_pkg::dma_ctl_t dma,    // DMA engine control
  input wire logic isa_master_owns,            // ISA master holds the bus
  input wire logic long_cycle_needed,          // Register needs long command
  input wire logic [7:0] reg_rd_data,          // Register read data
  input wire logic [3:0] cycle_status_bus_in,  // Status pins, input side
  input wire logic [31:2] host_address_lines,  // Host address pins
  input wire logic host_write_read,            // Host write/read pin
  input wire logic cmd_n,                      // Command strobe pin
  input wire logic transfer_ready_in,          // Ready pin, input side
  input wire logic [7:0] data_in,              // Data pins, input side
  output logic [3:0] cycle_status_bus_out,     // Status pins, output side
  output logic cycle_status_bus_oe_n,          // Status pin enable
  output logic transfer_ready_out,             // Ready pin, output side
  output logic transfer_ready_oe_n,            // Ready pin enable
  output logic [7:0] data_out,                 // Data pins, output side
  output logic data_oe_n,                      // Data pin enable
  output logic slave_select_out_n,             // Slave selected
  output logic above_16mb_flag_n,              // Above 16MB flag level
  output logic above_16mb_flag_oe_n,           // Above 16MB flag enable
  output logic above_1mb_flag_n,               // Above 1MB flag
  output logic address_enable_n,               // Address enable
  output logic expansion_bus_reset_out,        // Expansion bus reset
  output dma_bus_if_pkg::reg_access_t reg_acc, // Register access
  output logic burst_pipelining,               // Address pipelining on
  output logic dma_ready,                      // Cycle completion pulse
  output logic bus_free                        // No cycle in progress
);

  dma_bus_if_pkg::core_state_t s;       // Current state
  dma_bus_if_pkg::core_state_t next_s;  // Next state

  logic [3:0] st_s;       // Synchronised status pins
  logic [31:2] ha_s;      // Synchronised host address
  logic hwr_s;            // Synchronised write/read
  logic cmd_n_s;          // Synchronised command strobe
  logic rdy_s;            // Synchronised ready
  logic [7:0] din_s;      // Synchronised data
  logic slave_mode;       // Nobody inside owns the bus
  logic strobe_rise;      // Address strobe trailing edge
  logic [1:0] next_size;  // Size code about to be driven
  logic [31:0] flag_addr; // Address the 1MB decode looks at

  // All pins pass two flops; two cycles fit in the 3.5 clocks before T2
  pin_sync #(.W(45)) u_sync (  // [RULE_05]
    .clk(clk),
    .rst_n(rst_n),
    .d({cycle_status_bus_in, host_address_lines, host_write_read, cmd_n,
        transfer_ready_in, data_in}),
    .init('1),
    .q({st_s, ha_s, hwr_s, cmd_n_s, rdy_s, din_s})
  );

  // Helper terms shared by the next-state logic
  // slave_mode is the shared ownership term;
  // status and address enable use it, range flags use dma.owns.
  always_comb begin
    slave_mode = !dma.owns && !dma.refresh;
    strobe_rise = slave_mode && !s.strobe_prev && st_s[0];
    next_size = (dma.owns && dma.active && !dma.page_break) ?
                dma.size : `SIZE_IDLE;
    flag_addr = dma.owns ? {dma.addr, 2'h0} : {ha_s, 2'h0};
  end

  // Next state of the whole core
  always_comb begin
    next_s = s;
    // Levels hold by default; pulses are
    // cleared here and raised below.
    next_s.strobe_prev = st_s[0];
    next_s.acc.wr = 1'b0;
    next_s.acc.rd = 1'b0;
    next_s.dma_ready = 1'b0;
    next_s.rst_drv = 1'b0;  // [RULE_04]

    // Range flags and bus ownership
    // 1MB flag is registered after sync, so
    // it lags the pins instead of following.
    next_s.gt16_oe_n = !dma.owns;  // [RULE_02]
    next_s.gt16_n = !(dma.owns && ({dma.addr, 2'h0} > `ADDR_16MB_LIMIT));  // [RULE_01]
    next_s.gt1_n = !(flag_addr > `ADDR_1MB_LIMIT);  // [RULE_03]
    next_s.aen_n = slave_mode;  // [RULE_22]
    next_s.st_oe_n = slave_mode;  // [RULE_14]
    next_s.bus_free = slave_mode && st_s[3];  // [RULE_13]

    // Status port in master mode; all edges are the one bus clock edge
    next_s.st_out[1:0] = dma.timing;  // [RULE_06] [RULE_08]
    next_s.st_out[3:2] = next_size;  // [RULE_07] [RULE_09]

    // First ready sample after size leaves idle
    // Loaded with the new size; the last step
    // lands on the first edge at or after 2.5 clocks.
    if (s.st_out[3:2] == `SIZE_IDLE && next_size != `SIZE_IDLE) begin
      next_s.first_cnt = 2'(`RDY_SAMPLE_CYC);  // [RULE_17]
      next_s.armed = 1'b0;
    end else if (s.first_cnt != 2'h0) begin
      next_s.first_cnt = s.first_cnt - 2'h1;
      if (s.first_cnt == 2'h1) begin
        // Ready high here asks for burst address pipelining
        next_s.pipelining = rdy_s && !dma.page_break && !dma.last;  // [RULE_17]
        next_s.armed = 1'b1;
      end
    end else if (s.armed && s.st_out[3:2] != `SIZE_IDLE) begin
      next_s.dma_ready = rdy_s;  // [RULE_18]
    end

    // Pipelining ends at a page break or transfer end
    // A break wins over ready in the same cycle
    if (dma.page_break || dma.last) begin
      next_s.pipelining = 1'b0;  // [RULE_17]
    end
    // One more completion sample after idle when pipelining
    if (s.st_out[3:2] != `SIZE_IDLE && next_size == `SIZE_IDLE) begin
      next_s.armed = 1'b0;
      next_s.tail = s.pipelining || s.tail;  // [RULE_18]
    end else if (s.tail && rdy_s) begin
      next_s.tail = 1'b0;
      next_s.dma_ready = 1'b1;  // [RULE_18]
    end
    if (next_size == `SIZE_IDLE && !s.tail) begin
      next_s.pipelining = 1'b0;
    end

    // Slave cycle sequencing
    // Synced pins and slave_mode move the states
    unique case (s.sl)
      dma_bus_if_pkg::SL_IDLE: begin
        // New strobes are honoured only here
        if (strobe_rise) begin
          next_s.lat_addr = ha_s[15:2];  // [RULE_10]
          next_s.lat_mem = st_s[1];  // [RULE_10]
          next_s.lat_wr = hwr_s;  // [RULE_10]
          // Only I/O cycles reach the registers
          next_s.hit = !st_s[1] && ha_s[15:12] == `REG_BLOCK_BASE;  // [RULE_11]
          next_s.sl = dma_bus_if_pkg::SL_ADDR;
        end
      end
      dma_bus_if_pkg::SL_ADDR: begin
        if (!slave_mode) begin
          next_s.sl = dma_bus_if_pkg::SL_IDLE;
        end else if (!cmd_n_s) begin
          // Command seen: this edge is T2
          next_s.acc.int_ack = !st_s[2];  // [RULE_12]
          if (s.hit || !st_s[2]) begin
            next_s.sel_n = 1'b0;  // [RULE_20] [RULE_21]
            next_s.acc.addr = s.lat_addr;
            next_s.sl = dma_bus_if_pkg::SL_ACTIVE;
            if (!s.lat_wr || !st_s[2]) begin
              next_s.acc.rd = 1'b1;
              next_s.dout = reg_rd_data;
              next_s.dout_oe_n = 1'b0;  // [RULE_19]
            end
            // Hold-off only for long register cycles of ISA masters
            if (isa_master_owns && long_cycle_needed && s.hit && st_s[2]) begin
              next_s.rdy_out = 1'b0;  // [RULE_15]
              next_s.rdy_oe_n = 1'b0;
              next_s.rdy_cnt = 3'(`RDY_LOW_CYC);
            end
          end else begin
            next_s.sl = dma_bus_if_pkg::SL_IDLE;
          end
        end
      end
      dma_bus_if_pkg::SL_ACTIVE: begin
        // Ready hold-off counts down here
        if (s.rdy_cnt != 3'h0) begin
          next_s.rdy_cnt = s.rdy_cnt - 3'h1;
          if (s.rdy_cnt == 3'h1) begin
            next_s.rdy_out = 1'b1;  // [RULE_16]
          end
        end
        if (s.dout_oe_n == 1'b0) begin
          next_s.dout = reg_rd_data;
        end
        if (cmd_n_s || !slave_mode) begin
          // Command ended: write lands, everything lets go
          next_s.acc.wr = s.lat_wr && s.hit && !s.acc.int_ack && slave_mode;  // [RULE_19]
          next_s.acc.wdata = din_s;
          next_s.sel_n = 1'b1;  // [RULE_20]
          next_s.dout_oe_n = 1'b1;  // [RULE_23]
          next_s.rdy_oe_n = 1'b1;  // [RULE_16]
          next_s.rdy_out = 1'b1;
          next_s.rdy_cnt = 3'h0;
          next_s.sl = dma_bus_if_pkg::SL_IDLE;
        end
      end
      default: begin
        // Unused code: recover to idle
        next_s.sl = dma_bus_if_pkg::SL_IDLE;
      end
    endcase
  end

  // State register; reset floats every pin with an enable and asserts expansion reset
  // Strobe history starts high so reset
  // cannot fake a trailing strobe edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;  // [RULE_04]
      s.sl <= dma_bus_if_pkg::SL_IDLE;
      s.strobe_prev <= 1'b1;
      s.sel_n <= 1'b1;  // [RULE_21]
      s.rdy_out <= 1'b1;
      s.rdy_oe_n <= 1'b1;
      s.dout_oe_n <= 1'b1;  // [RULE_19]
      s.st_out <= 4'hF;
      s.st_oe_n <= 1'b1;  // [RULE_14]
      s.gt16_n <= 1'b1;
      s.gt16_oe_n <= 1'b1;  // [RULE_02]
      s.gt1_n <= 1'b1;
      s.aen_n <= 1'b1;  // [RULE_22]
      s.rst_drv <= 1'b1;  // [RULE_04]
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  // No logic here: every pin is a flop
  always_comb begin
    cycle_status_bus_out = s.st_out;
    cycle_status_bus_oe_n = s.st_oe_n;
    transfer_ready_out = s.rdy_out;
    transfer_ready_oe_n = s.rdy_oe_n;
    data_out = s.dout;
    data_oe_n = s.dout_oe_n;
    slave_select_out_n = s.sel_n;
    above_16mb_flag_n = s.gt16_n;
    above_16mb_flag_oe_n = s.gt16_oe_n;
    above_1mb_flag_n = s.gt1_n;
    address_enable_n = s.aen_n;
    expansion_bus_reset_out = s.rst_drv;
    reg_acc = s.acc;
    burst_pipelining = s.pipelining;
    dma_ready = s.dma_ready;
    bus_free = s.bus_free;
  end

  // Checks on the flag and ownership outputs
  a_gt16_high_addr: assert property (  // [RULE_01]
    @(posedge clk) disable iff (!rst_n)
    dma.owns && ({dma.addr, 2'h0} > `ADDR_16MB_LIMIT) |=> !above_16mb_flag_n)
    else $error("above 16MB flag not low for high DMA address");

  a_gt16_float: assert property (  // [RULE_02]
    @(posedge clk) disable iff (!rst_n)
    !dma.owns |=> above_16mb_flag_oe_n)
    else $error("above 16MB flag driven without DMA ownership");

  a_gt1_decode: assert property (  // [RULE_03]
    @(posedge clk) disable iff (!rst_n)
    slave_mode && ha_s[31:20] != 12'h000 |=> !above_1mb_flag_n)
    else $error("above 1MB flag missed a high host address");

  a_aen_owner: assert property (  // [RULE_22]
    @(posedge clk) disable iff (!rst_n)
    (dma.owns || dma.refresh) |=> !address_enable_n && !cycle_status_bus_oe_n)
    else $error("address enable or status not driven under DMA");

  a_status_float: assert property (  // [RULE_14]
    @(posedge clk) disable iff (!rst_n)
    slave_mode |=> cycle_status_bus_oe_n)
    else $error("status pins driven in slave mode");

  // Checks on the slave handshake
  // Release lags the command by sync plus one
  a_ready_owner: assert property (  // [RULE_15]
    @(posedge clk) disable iff (!rst_n)
    $fell(transfer_ready_oe_n) |-> $past(isa_master_owns && long_cycle_needed))
    else $error("ready driven for a master that must not see it");

  a_ready_hold: assert property (  // [RULE_16]
    @(posedge clk) disable iff (!rst_n || cmd_n_s)
    $fell(transfer_ready_out) |-> (!transfer_ready_out)[*4] ##1 transfer_ready_out)
    else $error("ready low time is not four clocks");

  a_select_t2: assert property (  // [RULE_20]
    @(posedge clk) disable iff (!rst_n)
    $fell(slave_select_out_n) |-> $past(!cmd_n_s) && $past(s.sl == dma_bus_if_pkg::SL_ADDR))
    else $error("slave select asserted before T2");

  a_data_select: assert property (  // [RULE_19]
    @(posedge clk) disable iff (!rst_n)
    !data_oe_n |-> !slave_select_out_n)
    else $error("data bus driven without slave select");

  // Checks on the master-mode ready sampling
  // These watch the counter and tail flag, not the pin
  a_first_sample: assert property (  // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    $past(s.st_out[3:2]) == `SIZE_IDLE && s.st_out[3:2] != `SIZE_IDLE
    |-> ##2 (s.first_cnt == 2'h1))
    else $error("first ready sample not at 2.5 clocks");

  a_tail_done: assert property (  // [RULE_18]
    @(posedge clk) disable iff (!rst_n)
    s.tail && rdy_s |=> dma_ready && !s.tail)
    else $error("final ready sample after idle missed");

endmodule : dma_peripheral_bus_interface

// *** dma_peripheral_bus_interface_tb.sv ***
/*
 * Self-checking bench for the DMA peripheral bus interface: reset,
 * slave cycles, master status, range flags and the ready handshake.
 * Assumes bus_ctl_model plays the bus controller and host.
 */
`timescale 1ns/1ps
`include "dma_bus_if_map.svh"
module dma_peripheral_bus_interface_tb;
  logic clk = 1'b0; // Bus clock
  logic rst_n = 1'b0; // System reset
  dma_bus_if_pkg::dma_ctl_t dma = '0; // DMA engine stimulus
  logic isa_master_owns = 1'b0; // ISA master owns the bus
  logic long_cycle_needed = 1'b0; // Long command wanted
  logic [7:0] reg_rd_data = 8'h00; // Register read data
  logic rdy_level = 1'b0; // Ready level in master mode
  logic rdy_on = 1'b0; // Model drives ready
  logic [3:0] st_pin, st_out;
  logic [7:0] d_pin, data_out;
  logic [31:2] ha;
  logic hwr, cmd_n, rdy_pin, st_oe_n, rdy_out, rdy_oe_n, data_oe_n, slave_select_out_n;
  logic above_16mb_flag_n, above_16mb_flag_oe_n, above_1mb_flag_n, address_enable_n;
  logic expansion_bus_reset_out, burst_pipelining, dma_ready, bus_free;
  dma_bus_if_pkg::reg_access_t reg_acc;
  int n_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int sel_cnt, rdy_low, rd_cnt, wr_cnt, oe_cnt, oe_bad, rdy_cnt; // Monitor counts
  logic [31:0] seed = 32'h694327c4; // Random state

  always #50 clk = ~clk;

  dma_peripheral_bus_interface dut (.clk(clk), .rst_n(rst_n), .dma(dma),
    .isa_master_owns(isa_master_owns), .long_cycle_needed(long_cycle_needed),
    .reg_rd_data(reg_rd_data), .cycle_status_bus_in(st_pin), .host_address_lines(ha),
    .host_write_read(hwr), .cmd_n(cmd_n), .transfer_ready_in(rdy_pin), .data_in(d_pin),
    .cycle_status_bus_out(st_out), .cycle_status_bus_oe_n(st_oe_n),
    .transfer_ready_out(rdy_out), .transfer_ready_oe_n(rdy_oe_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .slave_select_out_n(slave_select_out_n),
    .above_16mb_flag_n(above_16mb_flag_n), .above_16mb_flag_oe_n(above_16mb_flag_oe_n),
    .above_1mb_flag_n(above_1mb_flag_n), .address_enable_n(address_enable_n),
    .expansion_bus_reset_out(expansion_bus_reset_out), .reg_acc(reg_acc),
    .burst_pipelining(burst_pipelining), .dma_ready(dma_ready), .bus_free(bus_free));

  bus_ctl_model bus (.clk(clk), .st_out(st_out), .st_oe_n(st_oe_n), .rdy_out(rdy_out),
    .rdy_oe_n(rdy_oe_n), .d_out(data_out), .d_oe_n(data_oe_n), .rdy_level(rdy_level),
    .rdy_on(rdy_on), .st_pin(st_pin), .rdy_pin(rdy_pin), .d_pin(d_pin), .ha(ha),
    .hwr(hwr), .cmd_n(cmd_n));

  // Galois shift register, fixed seed so runs repeat
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Watch the pins every rising edge; counts are cleared between cycles
  always @(posedge clk) begin
    if (slave_select_out_n === 1'b0) sel_cnt++;
    if (rdy_oe_n === 1'b0 && rdy_out === 1'b0) rdy_low++;
    if (reg_acc.rd === 1'b1) rd_cnt++;
    if (reg_acc.wr === 1'b1) wr_cnt++;
    if (data_oe_n === 1'b0) oe_cnt++;
    // Data may only leave while selected, and must carry the register value
    if (data_oe_n === 1'b0 && (slave_select_out_n !== 1'b0 || data_out !== reg_rd_data)) oe_bad++;
    if (dma_ready === 1'b1) rdy_cnt++;
  end

  task automatic clear();
    @(negedge clk);
    {sel_cnt, rdy_low, rd_cnt, wr_cnt, oe_cnt, oe_bad, rdy_cnt} = '0;
  endtask : clear

  // One slave cycle with expectations worked out from its fields
  task automatic slave(input logic [31:2] a, input logic mem, input logic wr,
                       input logic interrupt_acknowledge_n, input logic isa, input logic lng);
    logic sel;
    sel = interrupt_acknowledge_n | (!mem && a[15:12] == `REG_BLOCK_BASE);
    clear();
    @(posedge clk);
    isa_master_owns <= isa;
    long_cycle_needed <= lng;
    reg_rd_data <= seed[15:8];
    bus.slave_cycle(a, mem, wr, interrupt_acknowledge_n, seed[7:0], lng ? 9 : 4);
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("select", sel_cnt != 0, sel);
    check("ready low", rdy_low, (sel && isa && lng && !interrupt_acknowledge_n) ? 4 : 0);
    check("read pulse", rd_cnt, sel && !wr);
    check("write pulse", wr_cnt, sel && wr);
    if (sel && wr) check("write data", reg_acc.wdata, seed[7:0]);
    if (sel) check("latched address", reg_acc.addr, a[15:2]);
    if (sel) check("int ack", reg_acc.int_ack, interrupt_acknowledge_n);
    check("bus free", bus_free, 1'b1);
    check("data enable", oe_cnt != 0, sel && !wr);
    check("data drive", oe_bad, 0);
    check("data float", {data_oe_n, slave_select_out_n}, 2'b11);
    check("1MB flag", above_1mb_flag_n, a[31:20] == 0);
  endtask : slave

  // Bus ownership and status codes, checked one cycle after they change
  task automatic master(input logic own, input logic rf, input logic [31:2] a,
                        input logic [3:0] code);
    @(posedge clk);
    dma <= '{owns: own, refresh: rf, addr: a, timing: code[1:0], size: code[3:2], active: own,
             default: 0};
    repeat (2) @(negedge clk);
    check("status enable", st_oe_n, !(own || rf));
    if (own) check("status", st_out, code);
    check("address enable", address_enable_n, !(own || rf));
    check("16MB enable", above_16mb_flag_oe_n, !own);
    if (own) check("16MB flag", above_16mb_flag_n, a[31:24] == 0);
    if (own) check("1MB flag dma", above_1mb_flag_n, a[31:20] == 0);
  endtask : master

  // Size leaves idle with ready held at one level; ready never changes mid-run
  task automatic burst(input logic rdy);
    @(posedge clk);
    dma <= '{owns: 1, active: 1, timing: 2'h3, size: `SIZE_IDLE, default: 0};
    rdy_on <= 1'b1;
    rdy_level <= rdy;
    repeat (4) @(posedge clk);
    dma.size <= 2'h2;
    repeat (6) @(negedge clk);
    check("pipelining", burst_pipelining, rdy);
    clear();
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("ready pulses", rdy_cnt, rdy ? 4 : 0);
    @(posedge clk);
    dma.size <= `SIZE_IDLE;
    repeat (6) @(posedge clk);
    dma <= '0;
    rdy_on <= 1'b0;
    $display("burst with ready %0d done", rdy);
  endtask : burst

  initial begin
    logic [31:2] a;
    logic mem, wr, interrupt_acknowledge_n, isa, lng;
    repeat (2) @(negedge clk);
    check("reset out", expansion_bus_reset_out, 1'b1);
    check("enables", {st_oe_n, rdy_oe_n, data_oe_n, above_16mb_flag_oe_n}, 4'hF);
    check("select idle", slave_select_out_n, 1'b1);
    check("aen idle", address_enable_n, 1'b1);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1; // Held eight clocks
    repeat (2) @(negedge clk);
    check("reset out released", expansion_bus_reset_out, 1'b0);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      a = seed[31:2];
      {mem, interrupt_acknowledge_n, wr, isa, lng} = {2'b00, seed[2:0]};
      if (i % 2 == 0) a[15:12] = `REG_BLOCK_BASE;
      case (i)
        0: {wr, isa, lng} = 3'b011;
        1: {a[31:20], a[15:12], wr, isa, lng} = {12'h000, `REG_BLOCK_BASE, 3'b110};
        2: mem = 1'b1;
        3: a[15:12] = ~`REG_BLOCK_BASE;
        4: {interrupt_acknowledge_n, wr, isa, lng} = 4'b1001;
        default: ;
      endcase
      slave(a, mem, wr, interrupt_acknowledge_n, isa, lng);
      $display("slave cycle %0d done", i);
    end
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      a = (i < 4) ? ((i % 2) ? 30'h0040_0000 : 30'h003F_FFFF) : seed[31:2];
      if (i == 2 || i == 3) a = (i == 2) ? 30'h0003_FFFF : 30'h0004_0000;
      master(i < 14, i == 14, a, i[3:0]);
    end
    $display("master status done");
    burst(1'b1);
    burst(1'b0);
    results();
  end

  // Whole run needs about 400 clocks; cut a hang at 5000 clocks
  initial begin
    #500_000;
    n_errors++;
    results();
  end
endmodule : dma_peripheral_bus_interface_tb

// *** pin_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes inputs are asynchronous to clk; only the second stage is used.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,           // Bus clock
  input wire logic rst_n,         // Asynchronous reset, active low
  input wire logic [W-1:0] d,     // Raw pin levels
  input wire logic [W-1:0] init,  // Unused reset hint, kept constant-free
  output logic [W-1:0] q          // Synchronised levels
);
  genvar i;
  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;  // First stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta <= 1'b1;
          q[i] <= 1'b1;
        end else begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate
endmodule : pin_sync
